// ---- hw/smtwsp_defs.vh ----
// Register addresses, field positions, reset values and counts of the two-wire serial port
`ifndef SMTWSP_DEFS_VH
`define SMTWSP_DEFS_VH

`define SMTWSP_MODE_ADDR 16'hff60
`define SMTWSP_BUSCTL_ADDR 16'hff61
`define SMTWSP_SVA_ADDR 16'hff62
`define SMTWSP_TIMING_ADDR 16'hff63
`define SMTWSP_SHIFT_ADDR 16'hff64

`define SMTWSP_MODE_RST 8'h01
`define SMTWSP_BUSCTL_RST 8'h00
`define SMTWSP_TIMING_RST 8'h00
`define SMTWSP_SVA_RST 8'h00
`define SMTWSP_SHIFT_RST 8'hff

`define SMTWSP_MODE_EN 7
`define SMTWSP_MODE_COI 6
`define SMTWSP_MODE_WUP 5
`define SMTWSP_MODE_SELH 4
`define SMTWSP_MODE_SELL 3
`define SMTWSP_MODE_PINSEL 2
`define SMTWSP_MODE_CLKSEL 1

`define SMTWSP_BC_BSYE 7
`define SMTWSP_BC_ACK_DETECTED_FLAG 6
`define SMTWSP_BC_AUTO_ACK_ENABLE 5
`define SMTWSP_BC_SOFTWARE_ACK_BIT 4
`define SMTWSP_BC_START_DETECTED_FLAG 3
`define SMTWSP_BC_STOP_DETECTED_FLAG 2
`define SMTWSP_BC_START_TRIGGER_BIT 1
`define SMTWSP_BC_STOP_TRIGGER_BIT 0

`define SMTWSP_TM_CLD 6
`define SMTWSP_TM_SIC 5
`define SMTWSP_TM_SVAM 4
`define SMTWSP_TM_CLC 3
`define SMTWSP_TM_WAIT_RELEASE_BIT 2
`define SMTWSP_TM_WAIT_SELECT_HIGH 1
`define SMTWSP_TM_WAIT_SELECT_LOW 0

`define SMTWSP_WAIT_8 2'b10
`define SMTWSP_WAIT_9 2'b11
`define SMTWSP_LAST_DATA 4'd7
`define SMTWSP_ACK_CLK 4'd8
`define SMTWSP_DONE_CLK 4'd9

`endif

// ---- hw/smtwsp_top.v ----
// Two-wire bus mode of the serial channel: master clocking, slave detection, registers, receive buffer
// What the document requires
// R1: Falling data while clock high is start
// R2: Seven address bits follow start; compare slave
// R3: Only matching slave participates until next start/stop; the code enforces this in wake-up mode only
// R4: Bit after address gives direction
// R5: Receiver acknowledges low after each byte
// R6: Transmitter samples acknowledge; master stops if none
// R7: Rising data while clock high is stop
// R8: Waiting slave holds clock line low
// R9: Master alone supplies the serial clock
// R10: Clock select chooses pin or timer clock
// R11: Mode bits 11 select bus mode; pin select
// R12: Wake-up limits interrupt to address match
// R13: Software sets stop source before wake-up
// R14: Address match flag, zero when disabled
// R15: Channel enable bit stops or runs channel
// R16: Stop trigger sets output latch, self-clears
// R17: Start trigger clears output latch, self-clears
// R18: Stop-detected flag set and clear conditions
// R19: Start-detected flag set and clear conditions
// R20: Software acknowledge drives data low immediately
// R21: Automatic acknowledge on ninth falling edge
// R22: Wait select field chooses interrupt and hold
// R23: Wait release bit ends wait, self-clears
// R24: Acknowledge-detected flag at ninth rising edge
// R25: Shift register write starts transfer, after wait
// R26: Bus inputs pass two synchroniser flops
`timescale 1ns/100ps
`default_nettype none
`include "smtwsp_defs.vh"

module smtwsp_top #(
    parameter RX_W = 8
) (
    input wire i_mclk,
    input wire i_sys_rst,
    input wire [15:0] i_addr,
    input wire i_wr,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    input wire i_timer_tick,
    input wire i_channel_clock_pin,
    output reg o_channel_clock_pin_out,
    output reg o_channel_clock_pin_oe,
    input wire i_data_line_a,
    output reg o_data_line_a_out,
    output reg o_data_line_a_oe,
    input wire i_data_line_b,
    output reg o_data_line_b_out,
    output reg o_data_line_b_oe,
    output reg o_channel_interrupt_flag,
    output reg o_rx_valid,
    output reg [RX_W-1:0] o_rx_data,
    input wire i_rx_ready
);

    reg [7:0] mode;
    reg bsye, auto_ack_enable, software_ack_bit, ack_detected_flag, start_detected_flag, stop_detected_flag;
    reg stop_interrupt_source_bit, svam, clc;
    reg [1:0] wat;
    reg [7:0] slave_address_register;
    reg [7:0] sr;
    reg so;
    reg busy, waiting, pend, ack_auto, partner, addr_phase, rx_hold, hold_low, scl_gen_low;
    reg [3:0] cnt;
    reg scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
    reg [RX_W-1:0] tail_data;
    reg tail_valid;
    wire en = mode[`SMTWSP_MODE_EN];
    wire wake_up_control_bit = mode[`SMTWSP_MODE_WUP];
    wire pinsel = mode[`SMTWSP_MODE_PINSEL];
    wire clk_sel = mode[`SMTWSP_MODE_CLKSEL];
    // R11: bus mode decode
    wire bus_on = en & mode[`SMTWSP_MODE_SELH] & mode[`SMTWSP_MODE_SELL];
    wire wr_mode = i_wr & (i_addr == `SMTWSP_MODE_ADDR);
    wire wr_bc = i_wr & (i_addr == `SMTWSP_BUSCTL_ADDR);
    wire wr_sva = i_wr & (i_addr == `SMTWSP_SVA_ADDR);
    wire wr_tm = i_wr & (i_addr == `SMTWSP_TIMING_ADDR);
    wire wr_shift = i_wr & (i_addr == `SMTWSP_SHIFT_ADDR);
    wire wait_release_bit = wr_tm & i_wdata[`SMTWSP_TM_WAIT_RELEASE_BIT];
    // R1: start detection on the synchronised lines
    wire start_det = bus_on & scl_s2 & scl_d & sda_d & ~sda_s2;
    // R7: stop detection on the synchronised lines
    wire stop_det = bus_on & scl_s2 & scl_d & ~sda_d & sda_s2;
    wire scl_rise = scl_s2 & ~scl_d;
    wire scl_fall = ~scl_s2 & scl_d;
    wire [7:0] amask = svam ? 8'hfe : 8'hff;
    // R14: comparator result, forced low when disabled
    wire address_match_flag = en & ((slave_address_register & amask) == (sr & amask));
    wire [7:0] next_byte = {sr[6:0], sda_s2};
    // R2: address bits compared with the slave address
    wire addr_match = (next_byte & amask) == (slave_address_register & amask);
    wire byte_done = busy & scl_rise & (cnt == `SMTWSP_LAST_DATA);
    wire ack_rise = busy & scl_rise & (cnt == `SMTWSP_ACK_CLK);
    wire end_fall = busy & scl_fall & (cnt == `SMTWSP_DONE_CLK);
    // R25: transfer begins on a write, deferred while a wait stands
    wire start_xfer = bus_on & ~busy & ~waiting & ~rx_hold & (wr_shift | pend) & ~(wake_up_control_bit & ~pend);
    wire fifo_room = ~tail_valid;
    wire push = fifo_room & (byte_done | rx_hold);
    wire [RX_W-1:0] push_data = byte_done ? next_byte[RX_W-1:0] : sr[RX_W-1:0];
    wire pop = o_rx_valid & i_rx_ready;
    wire sda_low = bus_on & ((~so & ~bsye) | software_ack_bit | ack_auto);
    // R12: interrupt source selection
    wire next_irq = (stop_det & stop_interrupt_source_bit) | (wake_up_control_bit ? (byte_done & addr_phase & addr_match)
        : ((byte_done & ~wat[0]) | (ack_rise & (wat == `SMTWSP_WAIT_9))));
    // R26: two flops on each bus line before any decision
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3f;
        end else begin
            scl_s1 <= i_channel_clock_pin;
            scl_s2 <= scl_s1;
            scl_d <= scl_s2;
            sda_s1 <= pinsel ? i_data_line_a : i_data_line_b;
            sda_s2 <= sda_s1;
            sda_d <= sda_s2;
        end
    end
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mode <= `SMTWSP_MODE_RST;
            {bsye, auto_ack_enable, software_ack_bit, ack_detected_flag, start_detected_flag, stop_detected_flag} <= 6'h00;
            {stop_interrupt_source_bit, svam, clc, wat} <= 5'h00;
            slave_address_register <= `SMTWSP_SVA_RST;
            sr <= `SMTWSP_SHIFT_RST;
            so <= 1'b1;
            {busy, waiting, pend, ack_auto, partner, addr_phase, rx_hold, hold_low, scl_gen_low} <= 9'h000;
            cnt <= 4'h0;
            o_channel_interrupt_flag <= 1'b0;
        end else begin
            o_channel_interrupt_flag <= bus_on & next_irq;
            if (wr_mode) begin
                mode <= {i_wdata[7], 1'b0, i_wdata[5:0]};
            end
            if (wr_sva) begin
                slave_address_register <= i_wdata;
            end
            if (wr_tm) begin
                {stop_interrupt_source_bit, svam, clc} <= i_wdata[5:3];
                wat <= i_wdata[1:0];
            end
            if (wr_bc) begin
                bsye <= i_wdata[`SMTWSP_BC_BSYE];
                auto_ack_enable <= i_wdata[`SMTWSP_BC_AUTO_ACK_ENABLE];
                // R20: software acknowledge drives the line at once
                if (i_wdata[`SMTWSP_BC_SOFTWARE_ACK_BIT]) begin
                    software_ack_bit <= 1'b1;
                end
                // R16: stop trigger raises the output latch
                if (i_wdata[`SMTWSP_BC_STOP_TRIGGER_BIT]) begin
                    so <= 1'b1;
                // R17: start trigger lowers the output latch
                end else if (i_wdata[`SMTWSP_BC_START_TRIGGER_BIT]) begin
                    so <= 1'b0;
                end
            end
            if (wr_shift & ~busy & ~wake_up_control_bit) begin
                sr <= i_wdata;
                if (waiting) begin
                    pend <= 1'b1;
                end
            end
            // R23: wait release clears the hold, bit reads zero
            if (wait_release_bit) begin
                waiting <= 1'b0;
            end
            // R18: transfer start clears the detected flags
            if (start_xfer) begin
                busy <= 1'b1;
                cnt <= 4'h0;
                start_detected_flag <= 1'b0;
                stop_detected_flag <= 1'b0;
                // R24: cleared at transfer start
                ack_detected_flag <= 1'b0;
                software_ack_bit <= 1'b0;
                pend <= 1'b0;
            end
            // R9: master clock generated from the selected tick
            // R10: internal clock only with clock select at one
            if (bus_on & clk_sel & busy & ~waiting & i_timer_tick) begin
                if (scl_gen_low & ~rx_hold) begin
                    scl_gen_low <= 1'b0;
                end else if (~scl_gen_low & scl_s2) begin
                    scl_gen_low <= 1'b1;
                end
            end
            if (busy & scl_fall) begin
                if (cnt < `SMTWSP_ACK_CLK) begin
                    // R4: direction bit shifted out like any other bit
                    so <= sr[7];
                end else if (cnt == `SMTWSP_ACK_CLK) begin
                    so <= 1'b1;
                    // R21: automatic acknowledge for this clock
                    // R5: receiver acknowledge, gated by participation only in wake-up mode
                    ack_auto <= auto_ack_enable & (~wake_up_control_bit | partner);
                    // R22: eight-clock wait holds the line
                    if (wat == `SMTWSP_WAIT_8) begin
                        waiting <= 1'b1;
                    end
                end
                if (rx_hold) begin
                    hold_low <= 1'b1;
                end
            end
            if (rx_hold & fifo_room) begin
                rx_hold <= 1'b0;
                hold_low <= 1'b0;
            end
            if (busy & scl_rise & (cnt < `SMTWSP_ACK_CLK)) begin
                sr <= next_byte;
                cnt <= cnt + 4'h1;
            end
            if (byte_done) begin
                if (~fifo_room) begin
                    rx_hold <= 1'b1;
                end
                if (addr_phase) begin
                    addr_phase <= 1'b0;
                    // R3: partner marks a match; a non-matching slave leaves only in wake-up mode
                    partner <= addr_match;
                    if (~addr_match) begin
                        stop_detected_flag <= 1'b0;
                        if (wake_up_control_bit) begin
                            busy <= 1'b0;
                        end
                    end
                end
            end
            // R24: acknowledge sampled on the ninth rise
            // R6: transmitter sees the acknowledge result here
            if (ack_rise) begin
                ack_detected_flag <= ~sda_s2;
                cnt <= `SMTWSP_DONE_CLK;
            end
            if (end_fall) begin
                busy <= 1'b0;
                ack_auto <= 1'b0;
                software_ack_bit <= 1'b0;
                scl_gen_low <= 1'b0;
                // R22: nine-clock wait holds the line
                // R8: clock held low until released
                if (wat == `SMTWSP_WAIT_9) begin
                    waiting <= 1'b1;
                end
            end
            // R19: start detection sets the flag
            if (start_det) begin
                start_detected_flag <= 1'b1;
                partner <= 1'b0;
                addr_phase <= 1'b1;
                if (wake_up_control_bit) begin
                    busy <= 1'b1;
                    cnt <= 4'h0;
                    so <= 1'b1;
                    scl_gen_low <= 1'b0;
                end
            end
            // R18: stop detection sets the flag
            // R19: and clears the start flag
            if (stop_det) begin
                stop_detected_flag <= 1'b1;
                start_detected_flag <= 1'b0;
                partner <= 1'b0;
                addr_phase <= 1'b0;
                if (~clk_sel) begin
                    busy <= 1'b0;
                end
            end
            // R15: disabled channel stops and clears its state
            if (~en) begin
                {software_ack_bit, ack_detected_flag, start_detected_flag, stop_detected_flag} <= 4'h0;
                {busy, waiting, pend, ack_auto, partner, addr_phase, rx_hold, hold_low, scl_gen_low} <= 9'h000;
                so <= 1'b1;
            end
        end
    end

    // Open-drain pins: output value stays low, enable pulls the line
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            {o_channel_clock_pin_out, o_channel_clock_pin_oe} <= 2'b00;
            {o_data_line_a_out, o_data_line_a_oe, o_data_line_b_out, o_data_line_b_oe} <= 4'h0;
        end else begin
            {o_channel_clock_pin_out, o_data_line_a_out, o_data_line_b_out} <= 3'h0;
            // R8: wait and buffer stall both hold the clock low
            o_channel_clock_pin_oe <= bus_on & (waiting | hold_low | (clk_sel & (scl_gen_low | (~busy & ~clc))));
            // R11: pin select picks the open-drain data line
            o_data_line_a_oe <= sda_low & pinsel;
            o_data_line_b_oe <= sda_low & ~pinsel;
        end
    end
    // Read data is registered one cycle after the address
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_rdata <= 8'h00;
        end else if (i_addr == `SMTWSP_MODE_ADDR) begin
            o_rdata <= {en, address_match_flag, mode[5:0]};
        end else if (i_addr == `SMTWSP_BUSCTL_ADDR) begin
            o_rdata <= {bsye, ack_detected_flag, auto_ack_enable, software_ack_bit, start_detected_flag, stop_detected_flag, 2'b00};
        end else if (i_addr == `SMTWSP_SVA_ADDR) begin
            o_rdata <= slave_address_register;
        end else if (i_addr == `SMTWSP_TIMING_ADDR) begin
            o_rdata <= {1'b0, en & scl_s2, stop_interrupt_source_bit, svam, clc, 1'b0, wat};
        end else if (i_addr == `SMTWSP_SHIFT_ADDR) begin
            o_rdata <= sr;
        end else begin
            o_rdata <= 8'h00;
        end
    end
    // Two-entry receive buffer: head register feeds the port, tail absorbs a stall
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            {o_rx_valid, tail_valid} <= 2'b00;
            {o_rx_data, tail_data} <= {2*RX_W{1'b0}};
        end else if (pop) begin
            if (tail_valid) begin
                o_rx_data <= tail_data;
                tail_valid <= 1'b0;
            end else if (push) begin
                o_rx_data <= push_data;
            end else begin
                o_rx_valid <= 1'b0;
            end
        end else if (push) begin
            if (~o_rx_valid) begin
                o_rx_data <= push_data;
                o_rx_valid <= 1'b1;
            end else begin
                tail_data <= push_data;
                tail_valid <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// ---- verification/smtwsp_checker.sv ----
// Port checker of the two-wire serial port, bound to its top
`timescale 1ns/100ps
`default_nettype none
module smtwsp_checker #(
    parameter RX_W = 8
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic [15:0] i_addr,
    input wire logic i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic i_timer_tick,
    input wire logic i_channel_clock_pin,
    input wire logic o_channel_clock_pin_out,
    input wire logic o_channel_clock_pin_oe,
    input wire logic i_data_line_a,
    input wire logic o_data_line_a_out,
    input wire logic o_data_line_a_oe,
    input wire logic i_data_line_b,
    input wire logic o_data_line_b_out,
    input wire logic o_data_line_b_oe,
    input wire logic o_channel_interrupt_flag,
    input wire logic o_rx_valid,
    input wire logic [RX_W-1:0] o_rx_data,
    input wire logic i_rx_ready
);
    logic [7:0] mode_q;
    wire bus_a = mode_q[7] && mode_q[4:3] == 2'b11 && mode_q[2];
    wire any_oe = o_data_line_a_oe || o_data_line_b_oe || o_channel_clock_pin_oe;
    // Shadow of the mode register
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mode_q <= 8'h01;
        end else if (i_wr && i_addr == 16'hff60) begin
            mode_q <= i_wdata;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    property p_open_drain; !o_channel_clock_pin_out && !o_data_line_a_out && !o_data_line_b_out; endproperty
    a_open_drain: assert property (p_open_drain) else $error("bus pin driven high");
    property p_start_latch; i_wr && i_addr == 16'hff61 && i_wdata[1] && bus_a |-> ##[1:3] o_data_line_a_oe; endproperty
    a_start_latch: assert property (p_start_latch) else $error("start trigger left data line high");
    property p_stop_latch; i_wr && i_addr == 16'hff61 && i_wdata[0] && !i_wdata[1] && bus_a |-> ##[1:3] !o_data_line_a_oe;
    endproperty
    a_stop_latch: assert property (p_stop_latch) else $error("stop trigger left data line low");
    property p_disable; i_wr && i_addr == 16'hff60 && !i_wdata[7] |-> ##2 (!any_oe) [*4]; endproperty
    a_disable: assert property (p_disable) else $error("disabled channel drives bus");
    property p_pin_sel; mode_q[2] && $past(mode_q[2]) && $past(mode_q[2], 2) |-> !o_data_line_b_oe; endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("unselected data pin driven");
    property p_mode_off; mode_q[4:3] != 2'b11 && $past(mode_q[4:3]) != 2'b11 && $past(mode_q[4:3], 2) != 2'b11 |-> !any_oe;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("bus driven outside bus mode");
    property p_irq_pulse; o_channel_interrupt_flag |=> !o_channel_interrupt_flag; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than a cycle");
    property p_match_off; $past(i_addr) == 16'hff60 && !$past(mode_q[7]) && !$past(mode_q[7], 2) |-> !o_rdata[6]; endproperty
    a_match_off: assert property (p_match_off) else $error("match flag set while disabled");
    property p_wait_rel; i_wr && i_addr == 16'hff63 && i_wdata[2] && i_wdata[3] && bus_a |-> ##[1:8] !o_channel_clock_pin_oe;
    endproperty
    a_wait_rel: assert property (p_wait_rel) else $error("wait release kept clock low");
    property p_rx_hold; o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data); endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receive word lost while stalled");
endmodule
bind smtwsp_top smtwsp_checker #(.RX_W(RX_W)) u_chk (.i_mclk, .i_sys_rst, .i_addr, .i_wr, .i_wdata, .o_rdata,
    .i_timer_tick, .i_channel_clock_pin, .o_channel_clock_pin_out, .o_channel_clock_pin_oe, .i_data_line_a,
    .o_data_line_a_out, .o_data_line_a_oe, .i_data_line_b, .o_data_line_b_out, .o_data_line_b_oe,
    .o_channel_interrupt_flag, .o_rx_valid, .o_rx_data, .i_rx_ready);
`default_nettype wire

// ---- verification/smtwsp_partner.sv ----
// Bus slave model that takes each byte and acknowledges it when i_ack_en is set
`timescale 1ns/100ps
`default_nettype none
module smtwsp_partner (
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_ack_en,
    output logic o_sda_oe,
    output logic [7:0] o_byte
);
    int bit_cnt = 0;
    initial o_sda_oe = 1'b0;
    initial o_byte = 8'h00;
    always @(negedge i_sda) begin
        if (i_scl) begin
            bit_cnt = 0;
        end
    end
    always @(posedge i_scl) begin
        if (bit_cnt >= 0 && bit_cnt < 8) begin
            o_byte = {o_byte[6:0], i_sda};
        end
        bit_cnt = bit_cnt + 1;
    end
    // ack on ninth clock
    // Master lets the clock rise to idle after the ninth fall; that rise carries no bit
    always @(negedge i_scl) begin
        if (bit_cnt >= 9) begin
            bit_cnt = -1;
        end
        o_sda_oe = bit_cnt == 8 && i_ack_en;
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Bench of the two-wire serial port as bus master
`timescale 1ns/100ps
`default_nettype none
`include "smtwsp_defs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [15:0] i_addr = 16'h0000;
    logic i_wr = 1'b0;
    logic [7:0] i_wdata = 8'h00;
    logic i_timer_tick = 1'b0;
    logic i_rx_ready = 1'b1;
    logic ack_en = 1'b1;
    logic [2:0] tick_cnt = 3'h0;
    logic [7:0] rd_val;
    int miscompares = 0;
    int checks_done = 0;
    wire [7:0] o_rdata;
    wire [7:0] rx_data;
    wire [7:0] p_byte;
    wire scl_oe, sda_a_oe, sda_b_oe, irq, rx_valid, p_oe;
    wire scl = !scl_oe;
    wire sda_a = !(sda_a_oe || p_oe);
    wire sda_b = !sda_b_oe;
    always #5 i_mclk = ~i_mclk;
    // Tick every six cycles gives a serial clock of 120 ns
    always @(posedge i_mclk) begin
        tick_cnt <= (tick_cnt == 3'h5) ? 3'h0 : tick_cnt + 3'h1;
        i_timer_tick <= tick_cnt == 3'h5;
    end
    smtwsp_top u_dut (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .i_timer_tick(i_timer_tick), .i_channel_clock_pin(scl), .o_channel_clock_pin_out(),
        .o_channel_clock_pin_oe(scl_oe), .i_data_line_a(sda_a), .o_data_line_a_out(), .o_data_line_a_oe(sda_a_oe),
        .i_data_line_b(sda_b), .o_data_line_b_out(), .o_data_line_b_oe(sda_b_oe), .o_channel_interrupt_flag(irq),
        .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(i_rx_ready));
    smtwsp_partner u_slave (.i_scl(scl), .i_sda(sda_a), .i_ack_en(ack_en), .o_sda_oe(p_oe), .o_byte(p_byte));
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wr <= 1'b1;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge i_mclk);
        i_addr <= a;
        repeat (2) @(posedge i_mclk);
        #1 rd_val = o_rdata;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack);
        int n;
        ack_en <= ack;
        wr(`SMTWSP_SHIFT_ADDR, d);
        for (n = 0; n < 3000 && irq !== 1'b1; n++) @(negedge i_mclk);
        `CHK("interrupt", 1'b1, irq)
        repeat (40) @(posedge i_mclk);
        `CHK("sent byte", d, p_byte)
        rd(`SMTWSP_BUSCTL_ADDR);
        `CHK("ack flag", ack, rd_val[6])
        `CHK("condition flags", 2'b00, rd_val[3:2])
    endtask
    task automatic pop(input logic [7:0] d);
        @(posedge i_mclk);
        #1;
        `CHK("rx valid", 1'b1, rx_valid)
        `CHK("rx data", d, rx_data)
        @(posedge i_mclk);
        i_rx_ready <= 1'b1;
        @(posedge i_mclk);
        i_rx_ready <= 1'b0;
    endtask
    task automatic t_reset;
        logic [15:0] adr [6] = '{16'hff60, 16'hff61, 16'hff62, 16'hff63, 16'hff64, 16'hff70};
        logic [7:0] exp [6] = '{`SMTWSP_MODE_RST, `SMTWSP_BUSCTL_RST, `SMTWSP_SVA_RST, `SMTWSP_TIMING_RST,
            `SMTWSP_SHIFT_RST, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(adr[i]);
            `CHK("reset value", exp[i], rd_val)
        end
        $display("test reset values done");
    endtask
    task automatic t_cond;
        wr(16'hff60, 8'h9e);
        wr(16'hff63, 8'h08);
        repeat (10) @(posedge i_mclk);
        wr(16'hff61, 8'h02);
        repeat (10) @(posedge i_mclk);
        rd(16'hff61);
        `CHK("start flag", 1'b1, rd_val[3])
        `CHK("trigger bits", 2'b00, rd_val[1:0])
        wr(16'hff61, 8'h01);
        repeat (10) @(posedge i_mclk);
        rd(16'hff61);
        `CHK("stop flag", 2'b01, rd_val[3:2])
        $display("test start and stop done");
    endtask
    task automatic t_xfer;
        xfer(8'h5a, 1'b0);
        xfer(8'ha5, 1'b1);
        $display("test master transmit done");
    endtask
    task automatic t_match;
        wr(16'hff62, 8'ha5);
        rd(16'hff60);
        `CHK("match flag", 1'b1, rd_val[6])
        wr(16'hff60, 8'h1e);
        rd(16'hff60);
        `CHK("match flag off", 1'b0, rd_val[6])
        rd(16'hff61);
        `CHK("flags off", 8'h00, rd_val)
        wr(16'hff64, 8'h77);
        rd(16'hff64);
        `CHK("shift loaded while off", 8'h77, rd_val)
        wr(16'hff60, 8'h9e);
        $display("test match and disable done");
    endtask
    task automatic t_wait;
        wr(16'hff63, 8'h0b);
        xfer(8'h3c, 1'b1);
        `CHK("wait hold", 1'b1, scl_oe)
        wr(16'hff63, 8'h0f);
        repeat (10) @(posedge i_mclk);
        `CHK("wait released", 1'b0, scl_oe)
        rd(16'hff63);
        `CHK("release bit", 1'b0, rd_val[2])
        $display("test wait done");
    endtask
    task automatic t_buf;
        wr(16'hff63, 8'h08);
        i_rx_ready <= 1'b0;
        xfer(8'h11, 1'b1);
        xfer(8'h22, 1'b1);
        wr(16'hff64, 8'h33);
        repeat (200) @(posedge i_mclk);
        `CHK("full stall", 1'b1, scl_oe)
        pop(8'h11);
        repeat (60) @(posedge i_mclk);
        pop(8'h22);
        pop(8'h33);
        #1;
        `CHK("buffer empty", 1'b0, rx_valid)
        $display("test receive buffer done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        t_reset();
        t_cond();
        t_xfer();
        t_match();
        t_wait();
        t_buf();
        end_of_test();
    end
    initial begin
        #300000;
        miscompares++;
        end_of_test();
    end
endmodule
`default_nettype wire
